// *** verilog/umsel_defs.vh ***
`ifndef UMSEL_DEFS_VH
`define UMSEL_DEFS_VH

// Modem status register field positions
`define UMSEL_MSR_DCTS      0
`define UMSEL_MSR_DDSR      1
`define UMSEL_MSR_TERI      2
`define UMSEL_MSR_DDCD      3
`define UMSEL_MSR_CTS       4
`define UMSEL_MSR_DSR       5
`define UMSEL_MSR_RI        6
`define UMSEL_MSR_DCD       7

// Register index of the modem status register on register_select_lines
`define UMSEL_ADDR_MSR      3'h6
`define UMSEL_ADDR_W        3

// Data bus width
`define UMSEL_DATA_W        8

// Reset levels
`define UMSEL_MSR_RST       8'h00
`define UMSEL_DATA_RST      8'h00

`endif

// *** verilog/umsel_sync2.v ***
`timescale 1ns/1ps
`default_nettype none

// ***********************************************
// Two-stage synchroniser for a bus of levels
// ***********************************************
module umsel_sync2 #(
  parameter W = 3
) (
  input  wire         clk_i,    // System clock
  input  wire         reset_i,  // Async reset, high
  input  wire [W-1:0] d_i,      // Asynchronous levels
  output reg  [W-1:0] q_o       // Synchronised levels
);

  reg [W-1:0] meta_r;

  // Only the second stage reads the first
  // Reset to the idle high level of the active-low modem pins, so the
  // first edges after reset never look like a change on idle pins
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r <= {W{1'b1}};
      q_o    <= {W{1'b1}};
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule

`default_nettype wire

// *** verilog/umsel_top.v ***
// Functional notes
// - Selected only when both high selects high and low select low.
// - Status bit 4 shows clear-to-send level; bit 0 flags its change.
// - Clear-to-send change interrupts only if enabled and auto flow off.
// - In auto clear-to-send mode, outside loop-back, the input gates the transmitter.
// - Bit 7 shows carrier-detect level; bit 3 flags its change.
// - Bit 5 shows data-set-ready level; bit 1 flags its change.
// - Carrier or data-set-ready change interrupts when modem interrupt enabled.
// - Change flags accumulate since last status read; the read clears them.
// - Eight-line data bus driven only during selected host reads.
// - Transceiver-disable low except while host reads the device.
// - Data-terminal-ready goes low when its control bit is set.
// - Data-terminal-ready high on reset, in loop-back, or bit cleared.
// - Interrupt active high for any enabled cause.
// - Interrupt drops once serviced or on master reset.
// - Master reset clears the change flags and sets outputs to reset levels; the address latch keeps its value.
// - Strobe low passes selects through; rising edge latches and holds them.
`timescale 1ns/1ps
`default_nettype none
`include "umsel_defs.vh"

module umsel_top (
  input  wire                      clk_i,                   // 100 MHz clock
  input  wire                      reset_i,                 // Async reset
  input  wire                      master_reset_in_i,       // Master reset
  input  wire                      select_high_a_i,         // Select, high
  input  wire                      select_high_b_i,         // Select, high
  input  wire                      select_low_n_i,          // Select, low
  input  wire                      address_latch_strobe_n_i,// Strobe, low
  input  wire [`UMSEL_ADDR_W-1:0]  register_select_lines_i, // Reg index
  input  wire                      host_read_i,             // Read strobe
  input  wire [`UMSEL_DATA_W-1:0]  host_data_lines_i,       // Bus input
  output reg  [`UMSEL_DATA_W-1:0]  host_data_lines_o,       // Bus output
  output reg                       host_data_lines_oe_o,    // Bus enable
  input  wire [`UMSEL_DATA_W-1:0]  other_read_data_i,       // Other regs
  input  wire                      cts_n_i,                 // Clear to send
  input  wire                      dsr_n_i,                 // Data set ready
  input  wire                      dcd_n_i,                 // Carrier detect
  input  wire                      modem_irq_en_i,          // Modem int enable
  input  wire                      auto_cts_en_i,           // Auto CTS mode
  input  wire                      dtr_ctrl_i,              // DTR control bit
  input  wire                      loopback_i,              // Loop-back mode
  input  wire                      other_irq_i,             // Other int causes
  output reg                       tx_allow_o,              // Tx may send
  output reg  [`UMSEL_DATA_W-1:0]  modem_status_o,          // MSR view
  output reg                       dtr_n_o,                 // DTR, low
  output reg                       transceiver_drive_off_o, // Drive off
  output reg                       irq_o                    // Interrupt
);

  // ***********************************************
  // Helper functions
  // ***********************************************
  // True when a register index points at the modem status register
  function is_status_idx;
    input [`UMSEL_ADDR_W-1:0] idx;
    begin
      is_status_idx = (idx == `UMSEL_ADDR_MSR);
    end
  endfunction

  // Next value of one change flag; a fresh change beats a read clear
  function flag_next;
    input chg;
    input old;
    input clr;
    begin
      flag_next = chg | (old & ~clr);
    end
  endfunction

  // ***********************************************
  // Local reset and address latch
  // ***********************************************
  wire rst_any = master_reset_in_i;

  reg                     sel_hold_r;
  reg [`UMSEL_ADDR_W-1:0] addr_hold_r;
  reg                     strobe_prev_r;

  wire sel_live = select_high_a_i & select_high_b_i & ~select_low_n_i;

  // Transparent while strobe low, held while high
  wire                     sel_eff  = address_latch_strobe_n_i ?
                                      sel_hold_r : sel_live;
  wire [`UMSEL_ADDR_W-1:0] addr_eff = address_latch_strobe_n_i ?
                                      addr_hold_r :
                                      register_select_lines_i;

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sel_hold_r    <= 1'b0;
      addr_hold_r   <= {`UMSEL_ADDR_W{1'b0}};
      strobe_prev_r <= 1'b0;
    end else begin
      strobe_prev_r <= address_latch_strobe_n_i;
      if (!address_latch_strobe_n_i) begin
        sel_hold_r  <= sel_live;
        addr_hold_r <= register_select_lines_i;
      end
    end
  end

  // ***********************************************
  // Modem input synchronisers
  // ***********************************************
  wire [2:0] modem_sync;

  umsel_sync2 #(
    .W(3)
  ) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     ({dcd_n_i, dsr_n_i, cts_n_i}),
    .q_o     (modem_sync)
  );

  reg [2:0] modem_prev_r;
  reg       prev_valid_r;
  reg       dcts_r;
  reg       ddsr_r;
  reg       ddcd_r;

  // First compare waits one cycle so reset levels never look like an edge
  wire [2:0] modem_chg = prev_valid_r ? (modem_sync ^ modem_prev_r)
                                      : 3'h0;

  wire rd_access = sel_eff & host_read_i;
  wire msr_read  = rd_access & is_status_idx(addr_eff);
  reg  msr_read_prev_r;
  // Clear on the trailing edge of a read so a long read sees stable data
  wire msr_read_end = msr_read_prev_r & ~msr_read;

  // ***********************************************
  // Previous-sample tracker and read-end detector
  // ***********************************************
  // Tracker resets to the idle high level of the pins, like the synchroniser
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      modem_prev_r    <= 3'h7;
      prev_valid_r    <= 1'b0;
      msr_read_prev_r <= 1'b0;
    end else if (rst_any) begin
      modem_prev_r    <= modem_sync;
      prev_valid_r    <= 1'b1;
      msr_read_prev_r <= 1'b0;
    end else begin
      modem_prev_r    <= modem_sync;
      prev_valid_r    <= 1'b1;
      msr_read_prev_r <= msr_read;
    end
  end

  // ***********************************************
  // Change flags: set wins over read clear
  // ***********************************************
  // Each flag has its own process so one can be traced alone
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dcts_r <= 1'b0;
    end else if (rst_any) begin
      dcts_r <= 1'b0;
    end else begin
      dcts_r <= flag_next(modem_chg[0], dcts_r, msr_read_end);
    end
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ddsr_r <= 1'b0;
    end else if (rst_any) begin
      ddsr_r <= 1'b0;
    end else begin
      ddsr_r <= flag_next(modem_chg[1], ddsr_r, msr_read_end);
    end
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ddcd_r <= 1'b0;
    end else if (rst_any) begin
      ddcd_r <= 1'b0;
    end else begin
      ddcd_r <= flag_next(modem_chg[2], ddcd_r, msr_read_end);
    end
  end

  // ***********************************************
  // Status composition and interrupt
  // ***********************************************
  // Level bits report the asserted (low-pin) state as one
  reg [`UMSEL_DATA_W-1:0] msr_nxt;
  always @* begin
    msr_nxt = `UMSEL_MSR_RST;
    msr_nxt[`UMSEL_MSR_DCTS] = dcts_r;
    msr_nxt[`UMSEL_MSR_DDSR] = ddsr_r;
    msr_nxt[`UMSEL_MSR_DDCD] = ddcd_r;
    msr_nxt[`UMSEL_MSR_CTS]  = ~modem_sync[0];
    msr_nxt[`UMSEL_MSR_DSR]  = ~modem_sync[1];
    msr_nxt[`UMSEL_MSR_DCD]  = ~modem_sync[2];
  end

  // A CTS change only counts as a modem interrupt outside auto-CTS mode
  wire modem_irq = modem_irq_en_i &
                   ((dcts_r & ~auto_cts_en_i) | ddsr_r | ddcd_r);
  wire irq_nxt   = modem_irq | other_irq_i;

  wire [`UMSEL_DATA_W-1:0] rd_data = is_status_idx(addr_eff) ?
                                     msr_nxt : other_read_data_i;

  // ***********************************************
  // Registered outputs
  // ***********************************************
  // Bus drive and transceiver control come from one decision, so the
  // external driver can never be on while the bus is driven
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      host_data_lines_o       <= `UMSEL_DATA_RST;
      host_data_lines_oe_o    <= 1'b0;
      transceiver_drive_off_o <= 1'b0;
    end else if (rst_any) begin
      host_data_lines_o       <= `UMSEL_DATA_RST;
      host_data_lines_oe_o    <= 1'b0;
      transceiver_drive_off_o <= 1'b0;
    end else begin
      host_data_lines_o       <= rd_access ? rd_data : `UMSEL_DATA_RST;
      host_data_lines_oe_o    <= rd_access;
      transceiver_drive_off_o <= rd_access;
    end
  end

  // Status copy for the rest of the device
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      modem_status_o <= `UMSEL_MSR_RST;
    end else if (rst_any) begin
      modem_status_o <= `UMSEL_MSR_RST;
    end else begin
      modem_status_o <= msr_nxt;
    end
  end

  // Terminal ready: inactive high unless the bit is set outside loop-back
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dtr_n_o <= 1'b1;
    end else if (rst_any) begin
      dtr_n_o <= 1'b1;
    end else begin
      dtr_n_o <= ~(dtr_ctrl_i & ~loopback_i);
    end
  end

  // Interrupt follows its causes with one cycle of latency
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else if (rst_any) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_nxt;
    end
  end

  // Transmit gate; loop-back keeps the pin out of the gate path
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_allow_o <= 1'b0;
    end else if (rst_any) begin
      tx_allow_o <= 1'b0;
    end else begin
      tx_allow_o <= ~auto_cts_en_i | loopback_i |
                    ~modem_sync[0];
    end
  end

endmodule

`default_nettype wire

// *** bench/umsel_modem.sv ***
`timescale 1ns/1ps
`default_nettype none
// ************************************
// Modem model driving the status lines
// ************************************
module umsel_modem (
  input  wire logic       clk_i,    // Clock
  input  wire logic [2:0] assert_i, // Wanted levels, DCD DSR CTS
  output var  logic       cts_n_o,  // Clear to send, low
  output var  logic       dsr_n_o,  // Data set ready, low
  output var  logic       dcd_n_o   // Carrier detect, low
);
  // Lines move just after an edge, never mid-cycle
  always @(posedge clk_i) begin
    {dcd_n_o, dsr_n_o, cts_n_o} <= ~assert_i;
  end
endmodule
`default_nettype wire

// *** bench/umsel_top_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module umsel_chk (
  input wire logic       clk_i,                    // Clock
  input wire logic       reset_i,                  // Reset
  input wire logic       master_reset_in_i,        // Master reset
  input wire logic       select_high_a_i,          // Select
  input wire logic       select_high_b_i,          // Select
  input wire logic       select_low_n_i,           // Select
  input wire logic       address_latch_strobe_n_i, // Strobe
  input wire logic       host_read_i,              // Read
  input wire logic [7:0] host_data_lines_o,        // Bus out
  input wire logic       host_data_lines_oe_o,     // Bus enable
  input wire logic       cts_n_i,                  // Modem
  input wire logic       dsr_n_i,                  // Modem
  input wire logic       dcd_n_i,                  // Modem
  input wire logic       dtr_ctrl_i,               // DTR bit
  input wire logic       loopback_i,               // Loop-back
  input wire logic [7:0] modem_status_o,           // Status
  input wire logic       dtr_n_o,                  // DTR
  input wire logic       transceiver_drive_off_o,  // Drive off
  input wire logic       irq_o                     // Interrupt
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire sel = select_high_a_i & select_high_b_i & ~select_low_n_i;
  wire run = ~master_reset_in_i;
  wire [2:0] pins = {dcd_n_i, dsr_n_i, cts_n_i};
  a_read_drives: assert property ((sel && host_read_i && run &&
    !address_latch_strobe_n_i) [*3] |-> host_data_lines_oe_o)
    else $error("selected read not driven");
  a_unsel_quiet: assert property ((!sel && !address_latch_strobe_n_i) [*3]
    |-> !host_data_lines_oe_o) else $error("bus driven unselected");
  a_bus_idle: assert property (!host_data_lines_oe_o
    |-> host_data_lines_o == 8'h00) else $error("data while idle");
  a_drive_off: assert property (transceiver_drive_off_o ==
    host_data_lines_oe_o) else $error("drive off mismatch");
  a_dtr_follow: assert property (1 |=> dtr_n_o == ($past(loopback_i) ||
    !$past(dtr_ctrl_i) || $past(master_reset_in_i)))
    else $error("dtr level wrong");
  a_status_level: assert property ((run && $stable(pins)) [*6] |->
    modem_status_o[7] == !dcd_n_i && modem_status_o[5] == !dsr_n_i
    && modem_status_o[4] == !cts_n_i) else $error("level bits wrong");
  a_flag_set: assert property (($changed(dcd_n_i) && !host_read_i && run)
    ##1 (!host_read_i && run) [*5] |-> modem_status_o[3])
    else $error("carrier change not flagged");
  a_mr_quiet: assert property (master_reset_in_i |=> !irq_o && dtr_n_o)
    else $error("master reset outputs wrong");
  c_read: cover property (host_data_lines_oe_o && modem_status_o[3]);
  c_irq: cover property (irq_o);
  c_mr: cover property (master_reset_in_i ##1 dtr_n_o);
endmodule
bind umsel_top umsel_chk umsel_chk_i (.*);
`default_nettype wire

// *** bench/umsel_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module umsel_top_tb;
  logic       clk_i, reset_i, master_reset_in_i, select_high_a_i;
  logic       select_high_b_i, select_low_n_i, address_latch_strobe_n_i;
  logic       host_read_i, modem_irq_en_i, auto_cts_en_i, dtr_ctrl_i;
  logic       loopback_i, other_irq_i, tx_allow_o, dtr_n_o, irq_o, cause;
  logic       transceiver_drive_off_o, host_data_lines_oe_o;
  logic [2:0] register_select_lines_i, lvl, flg, d;
  logic [7:0] host_data_lines_i, host_data_lines_o, other_read_data_i;
  logic [7:0] modem_status_o;
  logic [31:0] seed = 32'h9E031ABB;
  wire        cts_n_i, dsr_n_i, dcd_n_i;
  integer     error_cnt = 0, checks_done = 0, k;
  umsel_top umsel_top_i (.*);
  umsel_modem umsel_modem_i (.clk_i(clk_i), .assert_i(lvl),
    .cts_n_o(cts_n_i), .dsr_n_o(dsr_n_i), .dcd_n_o(dcd_n_i));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] st(input logic [2:0] l, f);
    st = {l[2], 1'h0, l[1], l[0], f[2], 1'h0, f[1], f[0]};
  endfunction
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("Checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Read held four edges, then three idle edges so flags settle
  task rd(input logic [2:0] idx, input logic en, input logic [7:0] exp);
    register_select_lines_i <= idx;
    host_read_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    #1;
    check(host_data_lines_oe_o, en);
    check(transceiver_drive_off_o, en);
    check(host_data_lines_o, exp);
    @(posedge clk_i);
    host_read_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    $display("Read of index %0d done", idx);
  endtask
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    {reset_i, master_reset_in_i, host_read_i, lvl, flg, cause} = 10'h200;
    {select_high_a_i, select_high_b_i, select_low_n_i} = 3'h6;
    {address_latch_strobe_n_i, register_select_lines_i} = 4'h6;
    {host_data_lines_i, other_read_data_i} = 16'h005A;
    {modem_irq_en_i, auto_cts_en_i, dtr_ctrl_i, loopback_i} = 4'h8;
    other_irq_i = 1'h0;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'h0;
    #1 check({dtr_n_o, irq_o, host_data_lines_oe_o}, 8'h04);
    repeat (8) @(posedge clk_i);
    rd(3'h6, 1'h1, 8'h00);
    // ************************
    // Random modem traffic
    // ************************
    for (k = 0; k < 10; k++) begin
      seed = lfsr(seed);
      if (flg == 3'h0) begin
        modem_irq_en_i <= seed[6];
        auto_cts_en_i  <= seed[4];
      end
      @(posedge clk_i);
      d = lvl ^ seed[2:0];
      flg = flg | d;
      cause = cause | modem_irq_en_i & (d[2] | d[1] | d[0] & !auto_cts_en_i);
      lvl <= seed[2:0];
      repeat (8) @(posedge clk_i);
      #1 check(irq_o, cause);
      check(tx_allow_o, !auto_cts_en_i | lvl[0]);
      @(posedge clk_i);
      if (seed[5]) begin
        rd(3'h6, 1'h1, st(lvl, flg));
        {flg, cause} = 4'h0;
        #1 check(irq_o, 1'h0);
        @(posedge clk_i);
      end
    end
    other_read_data_i <= seed[15:8];
    rd(3'h2, 1'h1, seed[15:8]);
    for (k = 0; k < 3; k++) begin
      {select_high_a_i, select_high_b_i, select_low_n_i} <= 3'h6 ^ (3'h1 << k);
      rd(3'h6, 1'h0, 8'h00);
    end
    {select_high_a_i, select_high_b_i, select_low_n_i} <= 3'h6;
    repeat (2) @(posedge clk_i);
    address_latch_strobe_n_i <= 1'h1;
    @(posedge clk_i);
    select_low_n_i <= 1'h1;
    rd(3'h6, 1'h1, st(lvl, flg));
    address_latch_strobe_n_i <= 1'h0;
    select_low_n_i <= 1'h0;
    for (k = 0; k < 4; k++) begin
      {dtr_ctrl_i, loopback_i} <= k[1:0];
      repeat (2) @(posedge clk_i);
      #1 check(dtr_n_o, !(k[1] & !k[0]));
      @(posedge clk_i);
    end
    {dtr_ctrl_i, loopback_i, other_irq_i, lvl} <= {3'h5, ~lvl};
    repeat (8) @(posedge clk_i);
    #1 check({irq_o, dtr_n_o}, 8'h02);
    @(posedge clk_i);
    {master_reset_in_i, other_irq_i} <= 2'h2;
    repeat (2) @(posedge clk_i);
    #1 check({irq_o, dtr_n_o}, 8'h01);
    @(posedge clk_i);
    master_reset_in_i <= 1'h0;
    repeat (8) @(posedge clk_i);
    rd(3'h6, 1'h1, st(lvl, 3'h0));
    give_verdict;
  end
endmodule
`default_nettype wire
